// >>> tcwc_core.sv
// Connection word control of a 256-channel time-slot interchange switch.
//
// Function
// - Loopback bit set: receive stream n channel m takes its transmitted byte.
// - Bit 14 picks variable (low) or constant (high) throughput delay.
// - Processor bit set: low byte of the word is transmitted.
// - Processor bit clear: stored byte at the source address is transmitted.
// - Bit 12 leaves on the control pin one channel early, stream 0 first.
// - Bit 11 high drives the transmit pin when control register bit 0 is set, low floats it for the channel.
// - Bits 9 to 7 give the source stream number.
// - Bits 4 to 0 give the source channel number.
// - Streams are numbered zero through seven.
// - Channels in a frame run from zero to 31.
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module tcwc_core
  import tcwc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire tcwc_bus_type busReq,
  output logic [15:0] readData,
  input wire logic bitClkPin,
  input wire logic frameSyncPin,
  input wire logic [7:0] rxPin,
  output logic [7:0] txOut,
  output logic [7:0] txOe_b,
  output logic ccOut
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] bitClkSync;
  logic [1:0] frameSync;
  logic [7:0] rxSync1;
  logic [7:0] rxSync2;
  logic riseTick;
  logic fallTick;
  logic frameMark;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bitClkSync <= 3'h0;
      frameSync <= 2'h0;
      rxSync1 <= 8'h00;
      rxSync2 <= 8'h00;
    end else if (ce) begin
      bitClkSync <= {bitClkSync[1:0], bitClkPin};
      frameSync <= {frameSync[0], frameSyncPin};
      rxSync1 <= rxPin;
      rxSync2 <= rxSync1;
    end
  end

  assign riseTick = bitClkSync[1] & ~bitClkSync[2];
  assign fallTick = ~bitClkSync[1] & bitClkSync[2];
  assign frameMark = frameSync[1];

  // ----------------------------------------------------------------------
  // Bit, channel and frame counters
  // ----------------------------------------------------------------------
  logic [2:0] bitPos;
  logic [4:0] chan;
  logic parity;
  logic boundary;

  // The frame mark is seen while the last bit of channel 31 is sampled.
  assign boundary = riseTick & (frameMark | (bitPos == LAST_BIT));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bitPos <= 3'h0;
      chan <= 5'h00;
      parity <= 1'b0;
    end else if (ce && riseTick) begin
      if (frameMark) begin
        bitPos <= 3'h0;
        chan <= 5'h00;
        parity <= ~parity;
      end else begin
        bitPos <= 3'(bitPos + 3'h1);
        if (bitPos == LAST_BIT) begin
          chan <= 5'(chan + 5'h01);
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Receive shifting and end-of-channel capture
  // ----------------------------------------------------------------------
  logic [7:0][7:0] rxShift;
  logic [7:0][7:0] rxByte;
  logic [7:0][7:0] rxHold;
  logic [7:0][7:0] txNext;
  logic [7:0][7:0] txHeld;
  tcwc_word_type [7:0] aheadWord;
  tcwc_word_type [7:0] nextWord;
  tcwc_word_type [7:0] curWord;
  logic [4:0] wrChan;
  logic wrBank;

  always_comb begin
    for (int s = 0; s < STREAMS; s++) begin
      rxByte[s] = {rxShift[s][6:0], rxSync2[s]};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rxShift <= '0;
      rxHold <= '0;
      wrChan <= 5'h00;
      wrBank <= 1'b0;
    end else if (ce && riseTick) begin
      rxShift <= rxByte;
      if (boundary) begin
        for (int s = 0; s < STREAMS; s++) begin
          rxHold[s] <= curWord[s].loopback ? txHeld[s] : rxByte[s];
        end
        wrChan <= chan;
        wrBank <= parity;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Per-channel sequencer: store received bytes, then load transmit bytes
  // ----------------------------------------------------------------------
  tcwc_seq_type seqState;
  logic [2:0] seqStep;
  logic storing;
  logic loading;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      seqState <= SEQ_IDLE;
      seqStep <= 3'h0;
    end else if (ce) begin
      if (boundary) begin
        seqState <= SEQ_STORE;
        seqStep <= 3'h0;
      end else begin
        case (seqState)
          SEQ_STORE: begin
            seqStep <= 3'(seqStep + 3'h1);
            if (seqStep == LAST_STREAM) begin
              seqState <= SEQ_LOAD;
            end
          end
          SEQ_LOAD: begin
            seqStep <= 3'(seqStep + 3'h1);
            if (seqStep == LAST_STREAM) begin
              seqState <= SEQ_IDLE;
            end
          end
          SEQ_IDLE: begin
            seqStep <= 3'h0;
          end
          default: begin
            seqState <= SEQ_IDLE;
            seqStep <= 3'h0;
          end
        endcase
      end
    end
  end

  assign storing = (seqState == SEQ_STORE);
  assign loading = (seqState == SEQ_LOAD);

  // ----------------------------------------------------------------------
  // Memory addressing
  // ----------------------------------------------------------------------
  tcwc_word_type loadWord;
  logic readBank;
  logic [8:0] dmWAddr;
  logic [8:0] dmRdAddr;
  logic [7:0] cmRdAddr;
  logic [7:0] dmRdData;
  logic [15:0] cmRdData;

  assign loadWord = nextWord[seqStep];

  // Constant delay reads the bank of the frame before the target slot;
  // variable delay reads the most recent write of the source channel.
  always_comb begin
    if (loadWord.constDelay) begin
      readBank = (chan == LAST_CHANNEL) ? parity : ~parity;
    end else begin
      readBank = (loadWord.srcChannel <= wrChan) ? wrBank : ~wrBank;
    end
  end

  assign dmWAddr = dm_index(wrBank, seqStep, wrChan);
  assign dmRdAddr = dm_index(readBank, loadWord.srcStream,
                             loadWord.srcChannel);
  assign cmRdAddr = cm_index(seqStep, 5'(chan + CHANNEL_LEAD));

  // ----------------------------------------------------------------------
  // Read pipeline and connection word stages
  // ----------------------------------------------------------------------
  logic cmRdValid;
  logic dmRdValid;
  logic [2:0] pipeStream;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmRdValid <= 1'b0;
      dmRdValid <= 1'b0;
      pipeStream <= 3'h0;
    end else if (ce) begin
      cmRdValid <= storing;
      dmRdValid <= loading;
      pipeStream <= seqStep;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      aheadWord <= '0;
      nextWord <= '0;
      curWord <= '0;
    end else if (ce) begin
      if (boundary) begin
        curWord <= nextWord;
        nextWord <= aheadWord;
      end
      if (cmRdValid) begin
        aheadWord[pipeStream] <= tcwc_word_type'(cmRdData);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txNext <= '0;
      txHeld <= '0;
    end else if (ce) begin
      if (boundary) begin
        txHeld <= txNext;
      end
      if (dmRdValid) begin
        if (nextWord[pipeStream].procChan) begin
          txNext[pipeStream] <= nextWord[pipeStream][7:0];
        end else begin
          txNext[pipeStream] <= dmRdData;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Transmit, driver enable and control-channel pins
  // ----------------------------------------------------------------------
  logic [7:0][7:0] txShift;
  logic [15:0] ctrlReg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txShift <= '0;
      txOut <= 8'h00;
      txOe_b <= 8'hff;
      ccOut <= 1'b0;
    end else if (ce) begin
      if (boundary) begin
        txShift <= txNext;
      end else if (fallTick) begin
        for (int s = 0; s < STREAMS; s++) begin
          txOut[s] <= txShift[s][7];
          txShift[s] <= {txShift[s][6:0], 1'b0};
          txOe_b[s] <= ~(ctrlReg[CTRL_DRIVE_BIT] & curWord[s].outEnable);
        end
        ccOut <= nextWord[bitPos].ctrlChan;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  logic hostCm;
  logic [15:0] bypassWord;

  assign hostCm = (busReq.addr[8] == CM_BASE_OFFSET[8]);

  always_comb begin
    if (busReq.addr == CTRL_OFFSET) begin
      bypassWord = ctrlReg;
    end else if (busReq.addr == STATUS_OFFSET) begin
      bypassWord = {7'h00, parity, chan, bitPos};
    end else begin
      bypassWord = 16'h0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrlReg <= CTRL_RESET;
    end else if (ce && busReq.write && busReq.addr == CTRL_OFFSET) begin
      ctrlReg <= busReq.wdata;
    end
  end

  tcwc_mem #(.WIDTH(WORD_WIDTH), .DEPTH(CM_DEPTH), .AW(CM_ADDR_WIDTH))
  connMem (
    .clk(clk),
    .rst_b(rst_b),
    .writeEnable(ce & busReq.write & hostCm),
    .writeAddr(busReq.addr[7:0]),
    .writeData(busReq.wdata),
    .readAEnable(ce & storing),
    .readAAddr(cmRdAddr),
    .readAData(cmRdData),
    .readBEnable(ce & busReq.read),
    .readBAddr(busReq.addr[7:0]),
    .bypassSelect(~hostCm),
    .bypassData(bypassWord),
    .readBData(readData)
  );

  tcwc_mem #(.WIDTH(BYTE_WIDTH), .DEPTH(DM_DEPTH), .AW(DM_ADDR_WIDTH))
  dataMem (
    .clk(clk),
    .rst_b(rst_b),
    .writeEnable(ce & storing),
    .writeAddr(dmWAddr),
    .writeData(rxHold[seqStep]),
    .readAEnable(ce & loading),
    .readAAddr(dmRdAddr),
    .readAData(dmRdData),
    .readBEnable(1'b0),
    .readBAddr(9'h000),
    .bypassSelect(1'b0),
    .bypassData(8'h00),
    .readBData()
  );

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  logic lpb0;
  logic [7:0] txHeld0;
  logic [7:0] rxByte0;
  logic [15:0] nw0;
  logic cco0;
  logic [7:0] txMsb;

  assign lpb0 = curWord[0].loopback;
  assign txHeld0 = txHeld[0];
  assign rxByte0 = rxByte[0];
  assign nw0 = nextWord[0];
  assign cco0 = nextWord[0].ctrlChan;
  always_comb begin
    for (int s = 0; s < STREAMS; s++) begin
      txMsb[s] = txShift[s][7];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  loopback_capture_a: assert property (ce && riseTick && boundary |=>
    rxHold[0] == ($past(lpb0) ? $past(txHeld0) : $past(rxByte0)))
    else $error("loopback capture took the wrong byte");
  const_bank_a: assert property (loading && loadWord.constDelay &&
    chan != LAST_CHANNEL |-> dmRdAddr[8] == ~parity)
    else $error("constant delay read the wrong bank");
  variable_bank_a: assert property (loading && !loadWord.constDelay &&
    loadWord.srcChannel <= wrChan |-> dmRdAddr[8] == wrBank)
    else $error("variable delay read the wrong bank");
  proc_byte_a: assert property (ce && dmRdValid && pipeStream == 3'h0 &&
    nw0[13] |=> txNext[0] == $past(nw0[7:0]))
    else $error("processor byte not loaded");
  switched_byte_a: assert property (ce && dmRdValid &&
    pipeStream == 3'h0 && !nw0[13] |=> txNext[0] == $past(dmRdData))
    else $error("switched byte not loaded");
  cco_lead_a: assert property (ce && fallTick && bitPos == 3'h0 |=>
    ccOut == $past(cco0))
    else $error("control bit of stream 0 not first");
  drive_gate_a: assert property (ce && fallTick && !boundary |=>
    txOut == $past(txMsb) && txOe_b[0] == !$past(curWord[0].outEnable &
    ctrlReg[CTRL_DRIVE_BIT]))
    else $error("transmit driver gating wrong");
  source_field_a: assert property (loading |->
    dmRdAddr[7:5] == loadWord.srcStream &&
    dmRdAddr[4:0] == loadWord.srcChannel)
    else $error("source fields not used as address");
  store_phase_a: assert property (ce && storing && seqStep == 3'h7 &&
    !boundary |=> loading && seqStep == 3'h0)
    else $error("store phase not eight streams long");
  frame_wrap_a: assert property (ce && riseTick && !frameMark &&
    bitPos == 3'h7 && chan == LAST_CHANNEL |=> chan == 5'h00)
    else $error("channel did not wrap after 31");
  fetch_addr_a: assert property (storing |->
    cmRdAddr == {seqStep, 5'(chan + CHANNEL_LEAD)})
    else $error("connection word fetched for wrong slot");

  loopback_c: cover property (ce && boundary && lpb0);
  proc_c: cover property (ce && dmRdValid && nw0[13]);
  const_c: cover property (loading && loadWord.constDelay);
  frame_c: cover property (ce && riseTick && frameMark ##1 storing);

endmodule
`default_nettype wire

// >>> tcwc_pkg.sv
// Package of constants, types and helpers for the connection word control.
package tcwc_pkg;

  // ----------------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------------
  localparam int STREAMS = 8;
  localparam int CHANNELS = 32;
  localparam int BYTE_WIDTH = 8;
  localparam int WORD_WIDTH = 16;
  localparam int CM_DEPTH = 256;
  localparam int CM_ADDR_WIDTH = 8;
  localparam int DM_DEPTH = 512;
  localparam int DM_ADDR_WIDTH = 9;
  localparam int BUS_ADDR_WIDTH = 9;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] LAST_STREAM = 3'h7;
  localparam logic [4:0] LAST_CHANNEL = 5'h1f;
  localparam logic [4:0] CHANNEL_LEAD = 5'h02;

  // ----------------------------------------------------------------------
  // Register map (word indices on the register port)
  // ----------------------------------------------------------------------
  localparam logic [8:0] CM_BASE_OFFSET = 9'h000;
  localparam logic [8:0] CTRL_OFFSET = 9'h100;
  localparam logic [8:0] STATUS_OFFSET = 9'h101;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam int CTRL_DRIVE_BIT = 0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic loopback;
    logic constDelay;
    logic procChan;
    logic ctrlChan;
    logic outEnable;
    logic spare10;
    logic [2:0] srcStream;
    logic [1:0] spare65;
    logic [4:0] srcChannel;
  } tcwc_word_type;

  typedef struct packed {
    logic write;
    logic read;
    logic [8:0] addr;
    logic [15:0] wdata;
  } tcwc_bus_type;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_STORE = 3'b010,
    SEQ_LOAD = 3'b100
  } tcwc_seq_type;

  // ----------------------------------------------------------------------
  // Address helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] cm_index(input logic [2:0] stream,
                                          input logic [4:0] chan);
    return {stream, chan};
  endfunction

  function automatic logic [8:0] dm_index(input logic bank,
                                          input logic [2:0] stream,
                                          input logic [4:0] chan);
    return {bank, stream, chan};
  endfunction

endpackage

// >>> tcwc_mem.sv
// Little memory with one write port and two registered read ports.
`timescale 1ns/1ps
`default_nettype none
module tcwc_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic writeEnable,
  input wire logic [AW-1:0] writeAddr,
  input wire logic [WIDTH-1:0] writeData,
  input wire logic readAEnable,
  input wire logic [AW-1:0] readAAddr,
  output logic [WIDTH-1:0] readAData,
  input wire logic readBEnable,
  input wire logic [AW-1:0] readBAddr,
  input wire logic bypassSelect,
  input wire logic [WIDTH-1:0] bypassData,
  output logic [WIDTH-1:0] readBData
);

  logic [WIDTH-1:0] store [DEPTH];

  always_ff @(posedge clk) begin
    if (writeEnable) begin
      store[writeAddr] <= writeData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      readAData <= '0;
    end else if (readAEnable) begin
      readAData <= store[readAAddr];
    end
  end

  // Port B can return a word from outside the array through its register.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      readBData <= '0;
    end else if (readBEnable) begin
      readBData <= bypassSelect ? bypassData : store[readBAddr];
    end
  end

endmodule
`default_nettype wire

// >>> tcwc_stream_partner.sv
// Far-side model of the serial streams: bit clock, frame mark and data.
`timescale 1ns/1ps
`default_nettype none
module tcwc_stream_partner
  import tcwc_pkg::*;
#(
  parameter int HALF = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  output logic bitClkPin,
  output logic frameSyncPin,
  output logic [7:0] rxPin,
  input wire logic [7:0] txOut,
  input wire logic [7:0] txOe_b,
  input wire logic ccOut,
  output logic [255:0] txFrame [8],
  output logic [255:0] oeFrame [8],
  output logic [255:0] ccFrame,
  output logic [15:0] frameCount
);
  logic [255:0] txShift [8];
  logic [255:0] oeShift [8];
  logic [255:0] ccShift;
  logic [7:0] slot;
  logic [7:0] nextSlot;
  logic [7:0] nextRx;
  logic [7:0] b;
  int phase;

  assign nextSlot = slot + 8'h01;

  // Each stream sends byte {channel, stream} ^ 0x5a, MSB first.
  always_comb begin
    for (int s = 0; s < 8; s++) begin
      b = {nextSlot[7:3], 3'(s)} ^ 8'h5a;
      nextRx[s] = b[~nextSlot[2:0]];
    end
  end

  // Data changes at the pin fall; line outputs are captured at the rise.
  // A floating transmit line is seen as the inverse of its last bit.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      phase <= 0;
      slot <= 8'hff;
      bitClkPin <= 1'b0;
      frameSyncPin <= 1'b0;
      rxPin <= 8'h00;
      frameCount <= 16'h0000;
    end else begin
      phase <= (phase == 2 * HALF - 1) ? 0 : phase + 1;
      if (phase == 0) begin
        bitClkPin <= 1'b1;
        ccShift <= {ccShift[254:0], ccOut};
        for (int s = 0; s < 8; s++) begin
          txShift[s] <= {txShift[s][254:0], txOut[s] ^ txOe_b[s]};
          oeShift[s] <= {oeShift[s][254:0], txOe_b[s]};
        end
        if (slot == 8'hff) begin
          ccFrame <= {ccShift[254:0], ccOut};
          for (int s = 0; s < 8; s++) begin
            txFrame[s] <= {txShift[s][254:0], txOut[s] ^ txOe_b[s]};
            oeFrame[s] <= {oeShift[s][254:0], txOe_b[s]};
          end
          frameCount <= frameCount + 16'h0001;
        end
      end
      if (phase == HALF) begin
        bitClkPin <= 1'b0;
        slot <= nextSlot;
        rxPin <= nextRx;
        frameSyncPin <= (nextSlot == 8'hff);
      end
    end
  end
endmodule
`default_nettype wire

// >>> tcwc_core_tb_top.sv
// Self-checking testbench of the connection word control.
`timescale 1ns/1ps
`default_nettype none
module tcwc_core_tb_top
  import tcwc_pkg::*;
;
  logic clk;
  logic rst_b;
  logic ce;
  tcwc_bus_type busReq;
  logic [15:0] readData;
  logic bitClkPin;
  logic frameSyncPin;
  logic [7:0] rxPin;
  logic [7:0] txOut;
  logic [7:0] txOe_b;
  logic ccOut;
  // The serial link stays idle until every connection word holds a value.
  logic linkOn;
  logic [255:0] txFrame [8];
  logic [255:0] oeFrame [8];
  logic [255:0] ccFrame;
  logic [15:0] frameCount;
  int badCount;
  int numChecks;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  tcwc_core u_tcwc_core (.clk(clk), .rst_b(rst_b), .ce(ce),
    .busReq(busReq), .readData(readData), .bitClkPin(bitClkPin),
    .frameSyncPin(frameSyncPin), .rxPin(rxPin), .txOut(txOut),
    .txOe_b(txOe_b), .ccOut(ccOut));

  tcwc_stream_partner u_tcwc_stream_partner (.clk(clk),
    .rst_b(rst_b & linkOn),
    .bitClkPin(bitClkPin), .frameSyncPin(frameSyncPin), .rxPin(rxPin),
    .txOut(txOut), .txOe_b(txOe_b), .ccOut(ccOut), .txFrame(txFrame),
    .oeFrame(oeFrame), .ccFrame(ccFrame), .frameCount(frameCount));

  // ----
  // Helpers
  // ----
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic busWrite(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk);
    busReq <= {1'b1, 1'b0, a, d};
    @(posedge clk);
    busReq <= '0;
  endtask

  task automatic busRead(input logic [8:0] a, output logic [15:0] v);
    @(posedge clk);
    busReq <= {1'b0, 1'b1, a, 16'h0000};
    @(posedge clk);
    busReq <= '0;
    #1 v = readData;
  endtask

  task automatic waitFrames(input int n);
    int start;
    start = frameCount;
    for (int i = 0; i < n * 5000 && frameCount < start + n; i++) @(posedge clk);
    if (frameCount < start + n) begin
      badCount++;
      $display("CHECK FAILED frame wait expected %0d seen %0d", n,
               frameCount - start);
      results();
    end
  endtask

  function automatic logic [7:0] rxByte(input int s, input int c);
    return {5'(c), 3'(s)} ^ 8'h5a;
  endfunction

  function automatic logic [7:0] pcByte(input int s, input int c);
    return {5'(c), 3'(s)} ^ 8'h3c;
  endfunction

  function automatic logic [7:0] lbByte(input int c);
    return {5'(c), 3'b101} ^ 8'h0f;
  endfunction

  function automatic logic ccBit(input int s, input int c);
    return s[0] ^ s[2] ^ c[0];
  endfunction

  // Bit 10 stays zero; bits 6 and 5 carry data only in processor words.
  function automatic logic [15:0] pcWord(input int s, input int c);
    return {3'b001, ccBit(s, c), (s != 7) | ~c[0], 3'b000,
            pcByte(s, c)};
  endfunction

  function automatic logic [255:0] expFrame(input int s, input int mode);
    logic [255:0] e;
    logic [7:0] b;
    for (int c = 0; c < 32; c++) begin
      case (mode)
        0: b = pcByte(s, c) ^ {8{s == 7 && c[0]}};
        1: b = rxByte(7 - s, 31 - c);
        2: b = (s == 7 && c[0]) ? 8'hff : 8'h00;
        4: b = lbByte(c);
        default: for (int k = 0; k < 8; k++) b[7 - k] = ccBit(k, (c + 1) % 32);
      endcase
      for (int k = 0; k < 8; k++) e[255 - (c * 8 + k)] = b[7 - k];
    end
    return e;
  endfunction

  function automatic logic [255:0] rot(input logic [255:0] v, input int r);
    logic [511:0] d;
    d = {v, v};
    return d[r +: 256];
  endfunction

  function automatic int rotFind(input logic [255:0] v, input logic [255:0] e);
    for (int r = 0; r < 256; r++) if (rot(v, r) === e) return r;
    return -1;
  endfunction

  // ----
  // Scenarios
  // ----
  task automatic scRegisters();
    logic [15:0] v;
    check("oe after reset", 16'(txOe_b), 16'h00ff);
    busWrite(9'h000, 16'hab9f);
    busWrite(9'h0ff, 16'h539a);
    busRead(9'h000, v);
    check("word 000", v, 16'hab9f);
    busRead(9'h0ff, v);
    check("word 0ff", v, 16'h539a);
    busRead(CTRL_OFFSET, v);
    check("ctrl reset", v, CTRL_RESET);
    busWrite(9'h102, 16'hffff);
    busRead(9'h102, v);
    check("unmapped", v, 16'h0000);
  endtask

  task automatic scProcessor();
    int r;
    for (int i = 0; i < 256; i++) busWrite(9'(i), pcWord(i / 32, i % 32));
    linkOn <= 1'b1;
    busWrite(CTRL_OFFSET, 16'h0001);
    waitFrames(3);
    r = rotFind(txFrame[0], expFrame(0, 0));
    check("proc align", 16'(r >= 0), 16'h0001);
    for (int s = 1; s < 8; s++) begin
      check("proc tx", 16'(rot(txFrame[s], r) === expFrame(s, 0)), 16'h1);
    end
    for (int s = 0; s < 8; s++) begin
      check("oe", 16'(rot(oeFrame[s], r) === expFrame(s, 2)), 16'h1);
    end
    check("cc", 16'(rot(ccFrame, r) === expFrame(0, 3)), 16'h1);
  endtask

  task automatic scSwitch(input logic cd);
    int r;
    for (int i = 0; i < 256; i++) begin
      busWrite(9'(i), {1'b0, cd, 4'b0010, 3'(7 - i / 32), 2'b00,
                       5'(31 - i % 32)});
    end
    waitFrames(3);
    r = rotFind(txFrame[0], expFrame(0, 1));
    check("switch align", 16'(r >= 0), 16'h0001);
    for (int s = 1; s < 8; s++) begin
      check("switch tx", 16'(rot(txFrame[s], r) === expFrame(s, 1)), 16'h1);
    end
  endtask

  // Input offsets are not modelled, so looped streams see zero offset.
  task automatic scLoopback();
    int r;
    for (int c = 0; c < 32; c++) begin
      busWrite(9'(c), {5'b10101, 3'b000, lbByte(c)});
      busWrite(9'(32 + c), {11'h040, 5'(c)});
    end
    waitFrames(3);
    r = rotFind(txFrame[0], expFrame(0, 4));
    check("loop align", 16'(r >= 0), 16'h0001);
    check("loop rx", 16'(rot(txFrame[1], r) === expFrame(1, 4)), 16'h1);
  endtask

  initial begin
    badCount = 0;
    numChecks = 0;
    rst_b = 1'b0;
    ce = 1'b1;
    linkOn = 1'b0;
    busReq = '0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    scRegisters();
    scProcessor();
    scSwitch(1'b0);
    scSwitch(1'b1);
    scLoopback();
    results();
  end
endmodule
`default_nettype wire
